// ==== hdl/udc_pkg.sv ====
// shared types and constants for the up/down counter core
package udc_pkg;

    // ------------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------------
    localparam int          CNT_W_DEF   = 16;       // default counter width
    localparam int          PRE_W       = 10;       // prescaler counter width, reaches 1/1024
    localparam logic [9:0]  PRE_RST     = 10'h000;  // prescaler counter reset value
    localparam logic        FLAG_RST    = 1'b0;     // overflow flag reset value
    localparam logic        DIR_UP      = 1'b0;     // count_direction value for up-counting
    localparam logic        DIR_DOWN    = 1'b1;     // count_direction value for down-counting

    // ------------------------------------------------------------------
    // clock_divider_select encodings
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        UDC_DIV1,
        UDC_DIV2,
        UDC_DIV4,
        UDC_DIV8,
        UDC_DIV16,
        UDC_DIV64,
        UDC_DIV256,
        UDC_DIV1024
    } udc_div_t;

    // ------------------------------------------------------------------
    // control word written by software, same clock as the core
    // ------------------------------------------------------------------
    typedef struct packed {
        logic     enable;          // run while high
        logic     soft_reset;      // one-cycle pulse, resets and disables
        logic     count_direction; // 0 up, 1 down
        logic     count_events;    // take ticks from event actions
        udc_div_t clock_divider_select;
        logic     cmd_clear;       // one-cycle pulse, clear at next tick
        logic     cmd_reload;      // one-cycle pulse, reload at next tick
        logic     flag_clear;      // one-cycle pulse, clears overflow_flag
    } udc_ctrl_t;

    // mask of low prescaler bits that must all be one for a tick
    function automatic logic [9:0] div_mask(input udc_div_t sel);
        case (sel)
            UDC_DIV1:    div_mask = 10'h000;
            UDC_DIV2:    div_mask = 10'h001;
            UDC_DIV4:    div_mask = 10'h003;
            UDC_DIV8:    div_mask = 10'h007;
            UDC_DIV16:   div_mask = 10'h00F;
            UDC_DIV64:   div_mask = 10'h03F;
            UDC_DIV256:  div_mask = 10'h0FF;
            UDC_DIV1024: div_mask = 10'h3FF;
            default:     div_mask = 10'h000;
        endcase
    endfunction

endpackage

// ==== hdl/udc_prescaler.sv ====
// clock prescaler producing one-cycle ticks at the selected division
`timescale 1ns/10ps
module udc_prescaler #(
    parameter int PW = udc_pkg::PRE_W
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // control
    input  wire logic             run,
    input  wire udc_pkg::udc_div_t sel,
    // tick out
    output logic                  tick
);

    // ------------------------------------------------------------------
    // divider counter
    // ------------------------------------------------------------------
    logic [PW-1:0] div_r;     // free count while running
    logic [PW-1:0] div_nxt;   // next count
    logic [PW-1:0] mask;      // low bits that define the period

    // next value: held at zero while stopped so a restart is aligned
    always_comb begin
        mask    = PW'(udc_pkg::div_mask(sel));
        div_nxt = div_r;
        if (!run) begin
            div_nxt = PW'(udc_pkg::PRE_RST);
        end else begin
            div_nxt = div_r + PW'(1);
        end
    end

    // register only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_r <= PW'(udc_pkg::PRE_RST);
        end else begin
            div_r <= div_nxt;
        end
    end

    // a tick each time the masked bits are all ones
    assign tick = run && ((div_r & mask) == mask);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // any division above one never gives two ticks in a row; a new ratio
    // may legally tick at once, so only a ratio held across both cycles is judged
    property p_div_spacing;
        @(posedge mclk) disable iff (rst)
        (run && tick && sel != udc_pkg::UDC_DIV1 && $stable(sel)) ##1 $stable(sel) |-> !tick;
    endproperty
    a_div_spacing: assert property (p_div_spacing)
        else $error("prescaler ticked on consecutive cycles");

endmodule

// ==== hdl/udc_core.sv ====
// up/down counter core of the control_timer with prescaler and event ticks
//
// How it works
// - event counting bypasses the clock prescaler
// - merged prescaler and event ticks advance counter
// - each tick clears, reloads, increments or decrements
// - clear or reload starts a new cycle
// - direction zero counts up, one down
// - up at top wraps to zero, flags
// - down at zero reloads top, flags
// - enable bit starts and stops the block
// - prescaler divides from 1 to 1/1024
`timescale 1ns/10ps
module udc_core #(
    parameter int CNT_W = udc_pkg::CNT_W_DEF
) (
    // clock and reset
    input  wire logic              MCLK,
    input  wire logic              RST,
    // software control word
    input  wire udc_pkg::udc_ctrl_t CTRL,
    // top value for wrap and reload
    input  wire logic [CNT_W-1:0]  TOP,
    // event action tick, one cycle, same clock
    input  wire logic              EVT_TICK,
    // status
    output logic [CNT_W-1:0]       COUNT,
    output logic                   OVERFLOW_FLAG,
    output logic                   CYCLE_START,
    output logic                   ENABLED
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] cnt_r;        // counter value
    logic [CNT_W-1:0] cnt_nxt;      // next counter value
    logic             en_r;         // block running
    logic             en_nxt;       // next running state
    logic             flag_r;       // sticky overflow_flag
    logic             flag_nxt;     // next flag
    logic             cyc_r;        // pulse: a new counting cycle began
    logic             cyc_nxt;      // next cycle pulse
    logic             clr_pend_r;   // clear command waiting for a tick
    logic             clr_pend_nxt; // next clear pending
    logic             rld_pend_r;   // reload command waiting for a tick
    logic             rld_pend_nxt; // next reload pending
    logic             ovf_hit;      // wrap or underflow on this tick
    logic             presc_tick;   // prescaler output
    logic             presc_run;    // prescaler enable
    logic             count_tick;   // merged tick stream
    logic             do_clear;     // clear selected on this tick
    logic             do_reload;    // reload selected on this tick

    // ------------------------------------------------------------------
    // tick source
    // ------------------------------------------------------------------
    // the prescaler idles while events drive the count, so it cannot
    // leak stray ticks into the event stream
    assign presc_run = en_r && !CTRL.count_events;

    udc_prescaler #(
        .PW   (udc_pkg::PRE_W)
    ) u_presc (
        .mclk (MCLK),
        .rst  (RST),
        .run  (presc_run),
        .sel  (CTRL.clock_divider_select),
        .tick (presc_tick)
    );

    // one stream: prescaled clock or event actions, never both
    assign count_tick = en_r &&
                        ((presc_tick && !CTRL.count_events) ||
                         (EVT_TICK && CTRL.count_events));

    // commands arriving in the tick cycle are honoured at once
    assign do_clear  = clr_pend_r || CTRL.cmd_clear;
    assign do_reload = !do_clear && (rld_pend_r || CTRL.cmd_reload);

    // ------------------------------------------------------------------
    // enable and pending commands
    // ------------------------------------------------------------------
    // soft reset wins over a still-high enable for one cycle; software
    // must drop its enable bit as well or the block restarts
    always_comb begin
        en_nxt       = CTRL.enable;
        clr_pend_nxt = clr_pend_r || CTRL.cmd_clear;
        rld_pend_nxt = rld_pend_r || CTRL.cmd_reload;
        if (count_tick) begin
            // consumed by the tick, whichever was chosen
            clr_pend_nxt = 1'b0;
            rld_pend_nxt = 1'b0;
        end
        if (CTRL.soft_reset) begin
            en_nxt       = 1'b0;
            clr_pend_nxt = 1'b0;
            rld_pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            en_r       <= 1'b0;
            clr_pend_r <= 1'b0;
            rld_pend_r <= 1'b0;
        end else begin
            en_r       <= en_nxt;
            clr_pend_r <= clr_pend_nxt;
            rld_pend_r <= rld_pend_nxt;
        end
    end

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    // exactly one update per tick, priority clear, reload, count
    always_comb begin
        cnt_nxt = cnt_r;
        cyc_nxt = 1'b0;
        ovf_hit = 1'b0;
        if (CTRL.soft_reset) begin
            cnt_nxt = '0;
        end else if (count_tick) begin
            if (do_clear) begin
                cnt_nxt = '0;
                cyc_nxt = 1'b1;
            end else if (do_reload) begin
                cnt_nxt = TOP;
                cyc_nxt = 1'b1;
            end else if (CTRL.count_direction == udc_pkg::DIR_UP) begin
                if (cnt_r == TOP) begin
                    // overflow: wrap to zero, a clear by nature
                    cnt_nxt = '0;
                    ovf_hit = 1'b1;
                    cyc_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                end
            end else begin
                if (cnt_r == '0) begin
                    // underflow: reload with top
                    cnt_nxt = TOP;
                    ovf_hit = 1'b1;
                    cyc_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - CNT_W'(1);
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // overflow flag
    // ------------------------------------------------------------------
    // a wrap in the very cycle of a clear must not be lost: set wins
    always_comb begin
        flag_nxt = flag_r;
        if (CTRL.flag_clear) begin
            flag_nxt = 1'b0;
        end
        if (ovf_hit) begin
            flag_nxt = 1'b1;
        end
        if (CTRL.soft_reset) begin
            flag_nxt = udc_pkg::FLAG_RST;
        end
    end

    // register the counter group
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            cnt_r  <= '0;
            cyc_r  <= 1'b0;
            flag_r <= udc_pkg::FLAG_RST;
        end else begin
            cnt_r  <= cnt_nxt;
            cyc_r  <= cyc_nxt;
            flag_r <= flag_nxt;
        end
    end

    // outputs come straight from flip-flops
    assign COUNT         = cnt_r;
    assign OVERFLOW_FLAG = flag_r;
    assign CYCLE_START   = cyc_r;
    assign ENABLED       = en_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    // a plain counting tick, no command and no soft reset
    sequence s_plain_tick;
        count_tick && !do_clear && !do_reload && !CTRL.soft_reset;
    endsequence

    property p_evt_bypass;
        (en_r && CTRL.count_events) |-> (count_tick == EVT_TICK);
    endproperty
    a_evt_bypass: assert property (p_evt_bypass)
        else $error("event mode tick does not follow event input");

    property p_no_tick_hold;
        (!count_tick && !CTRL.soft_reset) |=> (cnt_r == $past(cnt_r));
    endproperty
    a_no_tick_hold: assert property (p_no_tick_hold)
        else $error("counter moved without a tick");

    property p_clear;
        (count_tick && do_clear && !CTRL.soft_reset) |=> (cnt_r == '0) && cyc_r;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not zero the counter");

    property p_reload;
        (count_tick && do_reload && !CTRL.soft_reset) |=>
            (cnt_r == $past(TOP)) && cyc_r;
    endproperty
    a_reload: assert property (p_reload)
        else $error("reload did not start a new cycle");

    property p_count_dir;
        (s_plain_tick ##0 ((cnt_r != TOP) && (cnt_r != '0))) |=>
            (cnt_r == ($past(CTRL.count_direction) ? $past(cnt_r) - CNT_W'(1)
                                                   : $past(cnt_r) + CNT_W'(1)));
    endproperty
    a_count_dir: assert property (p_count_dir)
        else $error("counter stepped the wrong way");

    property p_overflow;
        (s_plain_tick ##0 (!CTRL.count_direction && (cnt_r == TOP))) |=>
            (cnt_r == '0) && flag_r && cyc_r;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow did not wrap and flag");

    property p_underflow;
        (s_plain_tick ##0 (CTRL.count_direction && (cnt_r == '0))) |=>
            (cnt_r == $past(TOP)) && flag_r;
    endproperty
    a_underflow: assert property (p_underflow)
        else $error("underflow did not reload top and flag");

    property p_enable;
        (!CTRL.soft_reset) |=> (en_r == $past(CTRL.enable));
    endproperty
    a_enable: assert property (p_enable)
        else $error("enable state does not follow the enable bit");

    property p_flag_sticky;
        (flag_r && !CTRL.flag_clear && !CTRL.soft_reset) |=> flag_r;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("overflow flag dropped without a clear");

    property p_disabled_hold;
        (!en_r && !CTRL.soft_reset) |=> $stable(cnt_r);
    endproperty
    a_disabled_hold: assert property (p_disabled_hold)
        else $error("counter moved while disabled");

endmodule

// ==== tb/udc_core_bench.sv ====
// self-checking bench for the up/down counter core
`timescale 1ns/10ps
module udc_core_bench;

    // ------------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------------
    logic               mclk;            // 200 MHz clock
    logic               rst;             // async reset, high
    udc_pkg::udc_ctrl_t ctrl;            // software control word
    logic [15:0]        top;             // wrap and reload value
    logic               evt_tick;        // event action tick
    logic [15:0]        count;           // counter value
    logic               overflow_flag;   // sticky wrap flag
    logic               cycle_start;     // new cycle pulse
    logic               enabled;         // block running
    int                 n_errors;        // mismatches seen
    int                 samples_checked; // comparisons made
    int                 divs [8] = '{1, 2, 4, 8, 16, 64, 256, 1024}; // divider per select

    udc_core #(.CNT_W(16)) u_udc_core (
        .MCLK(mclk), .RST(rst), .CTRL(ctrl), .TOP(top), .EVT_TICK(evt_tick),
        .COUNT(count), .OVERFLOW_FLAG(overflow_flag), .CYCLE_START(cycle_start),
        .ENABLED(enabled));

    // clock: toggles every half period
    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // step n edges, land 1 ns after the last so outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // compare the counter value
    task automatic chk_cnt(input logic [15:0] exp);
        samples_checked++;
        if (count !== exp) begin
            n_errors++;
            $display("ERROR t=%0t count got 0x%h exp 0x%h", $time, count, exp);
        end
    endtask

    // compare a single status bit
    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t flag got 0x%h exp 0x%h", $time, got, exp);
        end
    endtask

    // soft reset, configure while stopped, then raise enable (edge e0 + 1 ns)
    task automatic restart(input logic dir, input logic ev, input int sel,
                           input logic [15:0] t);
        udc_pkg::udc_ctrl_t c;
        c = '0;
        c.soft_reset = 1'b1;
        ctrl = c;
        tick(1);
        c.soft_reset = 1'b0;
        c.count_direction = dir;
        c.count_events = ev;
        c.clock_divider_select = udc_pkg::udc_div_t'(sel[2:0]);
        ctrl = c;
        top = t;
        tick(1);
        ctrl.enable = 1'b1;
    endtask

    // wait a bounded time for a cycle start pulse
    task automatic wait_cs();
        int k;
        for (k = 0; k < 8; k++) begin
            tick(1);
            if (cycle_start === 1'b1) break;
        end
        chk_bit(cycle_start, 1'b1);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // up count, wrap, sticky flag, clear, then hold while stopped
    task automatic test_up_walk();
        logic [15:0] snap;
        restart(udc_pkg::DIR_UP, 1'b0, 0, 16'h0002);
        tick(1); chk_bit(enabled, 1'b1);
        chk_cnt(16'h0000);
        tick(1); chk_cnt(16'h0001);
        tick(1); chk_cnt(16'h0002);
        tick(1); chk_cnt(16'h0000);
        chk_bit(overflow_flag, 1'b1);
        chk_bit(cycle_start, 1'b1);
        tick(1); chk_cnt(16'h0001);
        chk_bit(cycle_start, 1'b0);
        chk_bit(overflow_flag, 1'b1);
        ctrl.flag_clear = 1'b1;
        tick(1);
        ctrl.flag_clear = 1'b0;
        chk_bit(overflow_flag, 1'b0);
        tick(1); chk_bit(overflow_flag, 1'b1);
        // clear held into the next wrap: the wrap must win in that cycle
        ctrl.flag_clear = 1'b1;
        tick(3);
        ctrl.flag_clear = 1'b0;
        chk_cnt(16'h0000);
        chk_bit(overflow_flag, 1'b1);
        // stop: allow the in-flight tick to land before taking a snapshot
        ctrl.enable = 1'b0;
        tick(3);
        snap = count;
        tick(10); chk_cnt(snap);
        chk_bit(enabled, 1'b0);
    endtask

    // down count from zero: underflow reloads top and flags
    task automatic test_down();
        logic [15:0] exp [5] = '{16'h0003, 16'h0002, 16'h0001, 16'h0000, 16'h0003};
        int i;
        restart(udc_pkg::DIR_DOWN, 1'b0, 0, 16'h0003);
        tick(1); chk_bit(overflow_flag, 1'b0);
        for (i = 0; i < 5; i++) begin
            tick(1); chk_cnt(exp[i]);
            chk_bit(overflow_flag, 1'b1);
            chk_bit(cycle_start, (i == 0) || (i == 4));
        end
    endtask

    // every divider: exact tick spacing, event line held high but ignored
    task automatic test_prescaler();
        int i;
        evt_tick = 1'b1;
        for (i = 0; i < 8; i++) begin
            restart(udc_pkg::DIR_UP, 1'b0, i, 16'hFFFF);
            tick(divs[i]); chk_cnt(16'h0000);
            tick(1); chk_cnt(16'h0001);
            tick(divs[i] - 1); chk_cnt(16'h0001);
            tick(1); chk_cnt(16'h0002);
        end
        evt_tick = 1'b0;
    endtask

    // event mode with undivided clock: only events advance the counter
    task automatic test_events();
        restart(udc_pkg::DIR_UP, 1'b1, 0, 16'hFFFF);
        tick(5); chk_cnt(16'h0000);
        evt_tick = 1'b1;
        tick(3);
        evt_tick = 1'b0;
        chk_cnt(16'h0003);
        tick(2); chk_cnt(16'h0003);
    endtask

    // reload and clear wait for the divided tick; clear beats reload
    task automatic test_commands();
        restart(udc_pkg::DIR_UP, 1'b0, 2, 16'h0010);
        tick(1);
        ctrl.cmd_reload = 1'b1;
        tick(1);
        ctrl.cmd_reload = 1'b0;
        wait_cs(); chk_cnt(16'h0010);
        wait_cs(); chk_cnt(16'h0000);
        chk_bit(overflow_flag, 1'b1);
        ctrl.cmd_clear = 1'b1;
        ctrl.cmd_reload = 1'b1;
        tick(1);
        ctrl.cmd_clear = 1'b0;
        ctrl.cmd_reload = 1'b0;
        wait_cs(); chk_cnt(16'h0000);
    endtask

    // ------------------------------------------------------------------
    // verdict and main sequence
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        n_errors = 0;
        samples_checked = 0;
        ctrl = '0;
        top = 16'h0000;
        evt_tick = 1'b0;
        rst = 1'b1;
        tick(8);
        chk_cnt(16'h0000);
        chk_bit(overflow_flag, 1'b0);
        chk_bit(enabled, 1'b0);
        rst = 1'b0;
        tick(1);
        test_up_walk();
        test_down();
        test_prescaler();
        test_events();
        test_commands();
        summarize();
    end

    // watchdog: the full run needs about 3000 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        summarize();
    end

endmodule
